/* File: inc/wdc_pkg.sv */
package wdc_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] WDC_ADDR_COUNT_CONTROL = 8'hD8;
    localparam logic [7:0] WDC_RST_HW             = 8'hFF;
    localparam logic [7:0] WDC_RST_SW             = 8'hFE;
    localparam int         WDC_BIT_ACTIVATE       = 0;
    localparam int         WDC_BIT_SOFT_RESET     = 1;
    localparam int         WDC_FIELD_LO           = 2;
    localparam int         WDC_FIELD_HI           = 7;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int         WDC_STEP_CYCLES        = 3072;
    localparam logic [11:0] WDC_PRESCALE_LAST     = 12'(WDC_STEP_CYCLES - 1);
endpackage : wdc_pkg

/* File: inc/wdc_tick_if.sv */
`timescale 1ns/1ps
interface wdc_tick_if;
    logic restart;
    logic tick;
    modport src (input restart, output tick);
    modport dst (output restart, input tick);
endinterface : wdc_tick_if

/* File: design/wdc_prescaler.sv */
`timescale 1ns/1ps
module wdc_prescaler
    import wdc_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    wdc_tick_if.src  tk
);
    logic [11:0] cnt_q;
    logic [11:0] cnt_d;
    wire         at_last = (cnt_q == WDC_PRESCALE_LAST);

    // ------------------------------------------------------------
    // divide by step count, restarted by register writes
    // ------------------------------------------------------------
    assign cnt_d   = (tk.restart || at_last) ? 12'h000 : cnt_q + 12'h001;
    assign tk.tick = at_last && !tk.restart;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) cnt_q <= 12'h000;
        else       cnt_q <= cnt_d;
    end
endmodule : wdc_prescaler

/* File: design/wdc_watchdog.sv */
`timescale 1ns/1ps
module wdc_watchdog
    import wdc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       option_strap_pin,
    input  wire logic [7:0] bus_addr,
    input  wire logic [7:0] bus_wdata,
    input  wire logic       bus_wr,
    output logic      [7:0] bus_rdata,
    input  wire logic       stop_req,
    output logic            stop_as_wait,
    output logic            chip_reset_req
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [5:0] rev6(input logic [5:0] v);
        for (int i = 0; i < 6; i++) rev6[i] = v[5 - i];
    endfunction : rev6

    function automatic logic [6:0] rev7(input logic [6:0] v);
        for (int i = 0; i < 7; i++) rev7[i] = v[6 - i];
    endfunction : rev7

    typedef enum logic [2:0] {
        WDC_ST_INIT  = 3'b001,
        WDC_ST_TIMER = 3'b010,
        WDC_ST_WATCH = 3'b100
    } wdc_state_t;

    wdc_state_t  state_q;
    wdc_state_t  state_d;
    logic [7:0]  reg_q;
    logic [7:0]  reg_d;
    logic        rst_pulse_q;
    logic        rst_pulse_d;

    wdc_tick_if  tk ();

    wdc_prescaler u_pre (
        .clk  (clk),
        .nrst (nrst),
        .tk   (tk)
    );

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire        wr_hit   = bus_wr && (bus_addr == WDC_ADDR_COUNT_CONTROL);
    wire        hw_opt   = !option_strap_pin;
    wire        active   = (state_q == WDC_ST_WATCH);
    wire        tick     = tk.tick && (state_q != WDC_ST_INIT);
    // field counted with reversed significance
    wire  [5:0] field    = rev6(reg_q[WDC_FIELD_HI:WDC_FIELD_LO]);
    wire  [5:0] field_dn = rev6(field - 6'h01);
    wire  [6:0] tmr_dn   = rev7(rev7(reg_q[7:1]) - 7'h01);
    wire        wrap     = active && tick && !wr_hit && (field == 6'h00);
    // activation bit is sticky once set
    wire        act_new  = active || (wr_hit && bus_wdata[WDC_BIT_ACTIVATE]);
    wire  [7:0] wr_val   = {bus_wdata[7:1], act_new};
    wire        sr_clear = active && wr_hit && !bus_wdata[WDC_BIT_SOFT_RESET];
    wire        arm_bad  = (state_q == WDC_ST_TIMER) && wr_hit
                           && bus_wdata[WDC_BIT_ACTIVATE]
                           && !bus_wdata[WDC_BIT_SOFT_RESET];

    assign tk.restart     = wr_hit;
    assign bus_rdata      = reg_q;
    assign stop_as_wait   = active && stop_req;
    assign chip_reset_req = rst_pulse_q;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        state_d     = state_q;
        reg_d       = reg_q;
        rst_pulse_d = 1'b0;
        case (state_q)
            WDC_ST_INIT: begin
                // strap caught after reset release
                if (hw_opt) begin
                    state_d = WDC_ST_WATCH;
                    reg_d   = WDC_RST_HW;
                end else begin
                    state_d = WDC_ST_TIMER;
                    reg_d   = WDC_RST_SW;
                end
            end
            WDC_ST_TIMER: begin
                if (wr_hit) begin
                    reg_d = wr_val;
                    if (act_new) state_d = WDC_ST_WATCH;
                    rst_pulse_d = arm_bad;
                end else if (tick) begin
                    reg_d = {tmr_dn, 1'b0};
                end
            end
            WDC_ST_WATCH: begin
                if (wr_hit) begin
                    reg_d       = wr_val;
                    rst_pulse_d = sr_clear;
                end else if (tick) begin
                    reg_d = {field_dn, reg_q[1:0]};
                    rst_pulse_d = wrap;
                end
            end
            default: begin
                state_d = WDC_ST_INIT;
            end
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q     <= WDC_ST_INIT;
            reg_q       <= WDC_RST_HW;
            rst_pulse_q <= 1'b0;
        end else begin
            state_q     <= state_d;
            reg_q       <= reg_d;
            rst_pulse_q <= rst_pulse_d;
        end
    end
endmodule : wdc_watchdog

/* File: test/wdc_watchdog_chk.sv */
`timescale 1ns/1ps
module wdc_watchdog_chk
    import wdc_pkg::*;
(
    input wire logic       clk,
    input wire logic       nrst,
    input wire logic       option_strap_pin,
    input wire logic [7:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic       bus_wr,
    input wire logic [7:0] bus_rdata,
    input wire logic       stop_req,
    input wire logic       stop_as_wait,
    input wire logic       chip_reset_req
);
    wire       hit = bus_wr && bus_addr == WDC_ADDR_COUNT_CONTROL;
    // timeout field in natural bit order
    wire [5:0] fld = {<<{bus_rdata[7:2]}};
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_wr; hit && !bus_wdata[1] && (bus_rdata[0] || bus_wdata[0]); endsequence
    property p_stop; stop_as_wait == (stop_req && bus_rdata[0]); endproperty
    property p_pulse; chip_reset_req |=> !chip_reset_req; endproperty
    property p_srst; s_wr |-> ##[1:2] chip_reset_req; endproperty
    property p_load; hit && bus_wdata[1] |=> bus_rdata[7:1] == $past(bus_wdata[7:1]); endproperty
    property p_keep; $past(nrst) && bus_rdata[0] |=> bus_rdata[0]; endproperty
    property p_step; $past(nrst) && !$past(hit) && $changed(fld) && bus_rdata[0]
        |-> fld == 6'($past(fld) - 6'h01); endproperty
    property p_cause; chip_reset_req |-> $past(hit) || $past(hit, 2) || $past(fld) == 6'h00;
    endproperty
    property p_hwon; !option_strap_pin && $past(nrst) |-> bus_rdata[0]; endproperty
    a_stop: assert property (p_stop) else $error("stop view wrong");
    a_pulse: assert property (p_pulse) else $error("reset pulse long");
    a_srst: assert property (p_srst) else $error("no reset on write");
    a_load: assert property (p_load) else $error("write not loaded");
    a_keep: assert property (p_keep) else $error("activation cleared");
    a_step: assert property (p_step) else $error("bad decrement");
    a_cause: assert property (p_cause) else $error("reset without cause");
    a_hwon: assert property (p_hwon) else $error("hw option inactive");
endmodule : wdc_watchdog_chk
bind wdc_watchdog wdc_watchdog_chk u_chk (.*);

/* File: test/tb_wdc_watchdog.sv */
`timescale 1ns/1ps
module tb_wdc_watchdog
    import wdc_pkg::*;
;
    logic       clk = 1'h0, nrst = 1'h0, strap = 1'h1, wr = 1'h0, stop = 1'h0, sw, rq;
    logic [7:0] addr = 8'h00, wdat = 8'h00, rdat;
    int         miscompares = 0, tests_run = 0;
    wdc_watchdog u_wdc_watchdog (.clk(clk), .nrst(nrst), .option_strap_pin(strap),
        .bus_addr(addr), .bus_wdata(wdat), .bus_wr(wr), .bus_rdata(rdat),
        .stop_req(stop), .stop_as_wait(sw), .chip_reset_req(rq));
    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic wrt(logic [7:0] a, logic [7:0] d);
        addr = a;
        wdat = d;
        wr = 1'h1;
        @(negedge clk);
        wr = 1'h0;
    endtask : wrt
    // counts reset pulses over n cycles
    task automatic pls(int n, string s, logic [7:0] e);
        int c = 0;
        // sample first: the pulse stands in the cycle right after the write edge
        repeat (n) begin
            if (rq === 1'h1) c++;
            @(negedge clk);
        end
        chk(s, e, 8'(c));
    endtask : pls
    task automatic rst(logic s);
        nrst = 1'h0;
        strap = s;
        stop = 1'h0;
        repeat (8) @(negedge clk);
        nrst = 1'h1;
        repeat (2) @(negedge clk);
    endtask : rst
    task automatic t_sw;
        rst(1'h1);
        chk("sw reg", WDC_RST_SW, rdat);
        stop = 1'h1;
        @(negedge clk);
        chk("wait", 8'h00, {7'h00, sw});
        repeat (WDC_STEP_CYCLES - 1) @(negedge clk);
        chk("timer", 8'h7E, rdat);
        wrt(8'hD7, 8'h00);
        chk("other", 8'h7E, rdat);
        @(negedge clk);
        wrt(WDC_ADDR_COUNT_CONTROL, 8'h01);
        pls(3, "act rst", 8'h01);
        wrt(WDC_ADDR_COUNT_CONTROL, 8'hFE);
        chk("sticky", 8'hFF, rdat);
        chk("wait", 8'h01, {7'h00, sw});
        $display("t_sw done");
    endtask : t_sw
    task automatic t_hw;
        rst(1'h0);
        chk("hw reg", WDC_RST_HW, rdat);
        wrt(WDC_ADDR_COUNT_CONTROL, 8'h82);
        chk("load", 8'h83, rdat);
        pls(WDC_STEP_CYCLES, "early", 8'h00);
        chk("step", 8'h03, rdat);
        pls(WDC_STEP_CYCLES + 3, "expire", 8'h01);
        wrt(WDC_ADDR_COUNT_CONTROL, 8'hFD);
        pls(3, "soft", 8'h01);
        $display("t_hw done");
    endtask : t_hw
    task automatic stop_test;
        $display("miscompares %0d tests_run %0d", miscompares, tests_run);
        if (miscompares == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : stop_test
    initial forever #5 clk = ~clk;
    // about three times the expected run
    initial begin
        #300000;
        miscompares++;
        stop_test();
    end
    initial begin
        t_sw();
        t_hw();
        stop_test();
    end
endmodule : tb_wdc_watchdog
